//--- common/disk_dma_consts.svh
// Purpose: offsets, field positions and reset values of the disk DMA block
// Assumes: register addresses are the printed offsets on a 9-bit address
// Notes: definitions only
`ifndef DISK_DMA_CONSTS_SVH
`define DISK_DMA_CONSTS_SVH

// ==========================================================================
// register offsets
`define OFS_DATA_EARLY_READ 9'h008
`define OFS_BYTE_STATUS 9'h01A
`define OFS_INT_ENABLE_READ 9'h01C
`define OFS_INT_REQUEST_READ 9'h01E
`define OFS_POINTER_HIGH 9'h020
`define OFS_POINTER_LOW 9'h022
`define OFS_LENGTH_CONTROL 9'h024
`define OFS_DATA_WRITE 9'h026
`define OFS_SYNC_MATCH 9'h07E
`define OFS_INT_ENABLE_WRITE 9'h09A
`define OFS_INT_REQUEST_WRITE 9'h09C

// ==========================================================================
// field positions
`define LEN_ENABLE_BIT 15
`define LEN_DIRECTION_BIT 14
`define LEN_COUNT_MSB 13
`define GDC_MASTER_BIT 9
`define GDC_DISK_BIT 4
`define SET_CLEAR_BIT 15
`define INT_MASTER_BIT 14
`define INT_SYNC_BIT 12
`define INT_BLOCK_BIT 1

// ==========================================================================
// masks and reset values
`define INT_REQUEST_MASK 16'h3FFF
`define INT_ENABLE_MASK 16'h7FFF
`define INT_SOURCE_MASK 14'h3FFF
`define REG16_RESET 16'h0000
`define PTR_RESET 18'h00000

`endif

//--- common/disk_dma_pkg.sv
// Purpose: types shared by the disk DMA block and its helpers
// Assumes: constants live in disk_dma_consts.svh
// Notes: all state of the rtl modules is carried in the structs below
package disk_dma_pkg;

  typedef enum logic [2:0] {
    DMA_IDLE, DMA_COLLECT, DMA_STORE, DMA_FETCH, DMA_SEND_HI, DMA_SEND_LO
  } dma_state_t;

  typedef struct packed {
    logic [8:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_bus_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [17:0] addr;
    logic [15:0] wdata;
  } ram_req_t;

  typedef struct packed {
    dma_state_t st;
    logic active;
    logic [17:0] ptr;
    logic [15:0] len;
    logic [13:0] count;
    logic [15:0] data_buf;
    logic lo_next;
    logic byte_ready;
    logic [7:0] byte_data;
    logic [15:0] sync_pattern;
    logic done;
    ram_req_t ram;
    logic tx_valid;
    logic [7:0] tx_byte;
    logic [15:0] rdata;
    logic irq;
    logic [2:0] level;
  } disk_state_t;

  typedef struct packed {
    logic [7:0] prev;
    logic match;
    logic found;
  } sync_state_t;

  typedef struct packed {
    logic [15:0] bits;
  } flag_state_t;

endpackage : disk_dma_pkg

//--- rtl/set_clear_flags.sv
// Purpose: 16-bit set/clear flag register with hardware set events
// Assumes: events and writes come from logic on clk
// Notes: an event in the cycle of a clearing write keeps its bit set
`timescale 1ns/1ps
`include "disk_dma_consts.svh"
module set_clear_flags #(
  parameter logic [15:0] MASK = 16'hFFFF
) (
  input wire logic clk, // system clock
  input wire logic reset, // synchronous, active high
  input wire logic wr, // write strobe for this register
  input wire logic [15:0] wdata, // written word, bit 15 selects set or clear
  input wire logic [15:0] events, // one-cycle set pulses from hardware
  output logic [15:0] value // current flags
);
  disk_dma_pkg::flag_state_t r, n;

  always_comb begin
    n = r;
    if (wr) begin
      if (wdata[`SET_CLEAR_BIT]) begin
        n.bits = r.bits | (wdata & MASK);
      end else begin
        n.bits = r.bits & ~(wdata & MASK);
      end
    end
    n.bits = n.bits | (events & MASK);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r <= '{bits: `REG16_RESET};
    end else begin
      r <= n;
    end
  end

  assign value = r.bits;

  setclr_hold_a: assert property (@(posedge clk) disable iff (reset)
    wr && !wdata[`SET_CLEAR_BIT] && (events & wdata & MASK) == 16'h0000
    |=> (value & $past(wdata) & MASK) == 16'h0000)
    else $error("clearing write left a flag set");
endmodule : set_clear_flags

//--- rtl/sync_word_match.sv
// Purpose: compares the last two disk bytes with the sync pattern
// Assumes: bytes arrive as one-cycle strobes on clk
// Notes: the match level holds until the next byte replaces the pair
`timescale 1ns/1ps
module sync_word_match (
  input wire logic clk, // system clock
  input wire logic reset, // synchronous, active high
  input wire logic rx_valid, // a disk byte is present
  input wire logic [7:0] rx_byte, // the disk byte
  input wire logic [15:0] pattern, // sync pattern to look for
  output logic match, // last two bytes equal the pattern
  output logic found // one-cycle pulse on a matching byte
);
  disk_dma_pkg::sync_state_t r, n;

  always_comb begin
    n = r;
    n.found = 1'b0;
    if (rx_valid) begin
      n.prev = rx_byte;
      n.match = ({r.prev, rx_byte} == pattern);
      n.found = n.match;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r <= '{prev: 8'h00, match: 1'b0, found: 1'b0};
    end else begin
      r <= n;
    end
  end

  assign match = r.match;
  assign found = r.found;

  sync_level_a: assert property (@(posedge clk) disable iff (reset)
    rx_valid |=> match == ($past({r.prev, rx_byte}) == $past(pattern)))
    else $error("sync flag does not follow the byte pair");
endmodule : sync_word_match

//--- rtl/disk_dma_interrupt_control.sv
// Purpose: disk DMA channel with byte status, sync match and interrupt flags
// Assumes: disk bytes, RAM answers and global DMA control come from logic on clk
// Notes: the RAM port holds a request until ram_ack; tx holds until ready
// Function
// - length register: bit 15 enable, bit 14 direction, bits 13-0 words
// - when the word count reaches zero raise the block finished request
// - a two-byte buffer; each word moves between it and RAM automatically
// - read mode bytes go to status low byte, bit 15 set, read clears
// - status bit 14 is length enable AND global master enable
// - status bit 13 mirrors the direction bit of the length register
// - status bit 12 true only while disk data equals the sync pattern
// - writable sync pattern; a match raises the sync interrupt request
// - request flags readable; interrupt only when the enable bit is set
// - enable bit 14 is a master gate and not a request flag
// - request and enable share one bit layout with fixed priority levels
// - written bit 15 picks set or clear; zero bits stay unchanged
// - disk DMA runs only while global bits 9 and 4 are set; a word in DMA_STORE, DMA_SEND_HI, DMA_SEND_LO or DMA_FETCH with its RAM request out still finishes
`timescale 1ns/1ps
`include "disk_dma_consts.svh"
module disk_dma_interrupt_control (
  input wire logic clk, // system clock, 100 MHz
  input wire logic reset, // synchronous, active high
  input disk_dma_pkg::reg_bus_t bus, // register address, data and strobes
  output logic [15:0] rdata, // read data, cycle after the read strobe
  input wire logic [15:0] global_dma_control, // global DMA control word
  input wire logic [15:0] other_events, // set pulses from other sources
  output disk_dma_pkg::ram_req_t ram, // RAM request, held until ack
  input wire logic ram_ack, // RAM finished the request
  input wire logic [15:0] ram_rdata, // RAM word, valid with ram_ack
  input wire logic disk_rx_valid, // a byte arrived from the disk
  input wire logic [7:0] disk_rx_byte, // the received byte
  output logic disk_tx_valid, // a byte waits for the disk
  output logic [7:0] disk_tx_byte, // byte to write to the disk
  input wire logic disk_tx_ready, // the disk took the byte
  output logic irq, // level interrupt request
  output logic [2:0] int_level // priority level of the request
);
  disk_dma_pkg::disk_state_t r, n;
  logic go;
  logic sync_match;
  logic sync_found;
  logic [15:0] int_request;
  logic [15:0] int_enable;
  logic [15:0] int_events;
  logic [15:0] byte_status;

  // ==========================================================================
  // helpers
  function automatic disk_dma_pkg::disk_state_t advance(
    input disk_dma_pkg::disk_state_t s
  );
    disk_dma_pkg::disk_state_t t;
    t = s;
    t.ptr = s.ptr + 18'h00001;
    t.count = s.count - 14'h0001;
    return t;
  endfunction : advance

  // fixed priority: higher bit groups win
  function automatic logic [2:0] level_of(input logic [13:0] p);
    logic [2:0] l;
    l = 3'h0;
    if (p[13]) begin
      l = 3'h6;
    end else if (|p[12:11]) begin
      l = 3'h5;
    end else if (|p[10:7]) begin
      l = 3'h4;
    end else if (|p[6:4]) begin
      l = 3'h3;
    end else if (p[3]) begin
      l = 3'h2;
    end else if (|p[2:0]) begin
      l = 3'h1;
    end
    return l;
  endfunction : level_of

  // ==========================================================================
  // helper blocks
  sync_word_match sync_u (
    .clk(clk),
    .reset(reset),
    .rx_valid(disk_rx_valid),
    .rx_byte(disk_rx_byte),
    .pattern(r.sync_pattern),
    .match(sync_match),
    .found(sync_found)
  );

  always_comb begin
    int_events = other_events;
    int_events[`INT_BLOCK_BIT] = other_events[`INT_BLOCK_BIT] | r.done;
    int_events[`INT_SYNC_BIT] = other_events[`INT_SYNC_BIT] | sync_found;
  end

  // flags only change by hardware events or explicit writes
  set_clear_flags #(.MASK(`INT_REQUEST_MASK)) request_u (
    .clk(clk),
    .reset(reset),
    .wr(bus.wr && bus.addr == `OFS_INT_REQUEST_WRITE),
    .wdata(bus.wdata),
    .events(int_events),
    .value(int_request)
  );

  set_clear_flags #(.MASK(`INT_ENABLE_MASK)) enable_u (
    .clk(clk),
    .reset(reset),
    .wr(bus.wr && bus.addr == `OFS_INT_ENABLE_WRITE),
    .wdata(bus.wdata),
    .events(16'h0000),
    .value(int_enable)
  );

  // ==========================================================================
  // next state
  always_comb begin
    n = r;
    n.done = 1'b0;
    n.rdata = 16'h0000;
    go = r.len[`LEN_ENABLE_BIT] && global_dma_control[`GDC_MASTER_BIT]
      && global_dma_control[`GDC_DISK_BIT];
    byte_status = {r.byte_ready,
      r.len[`LEN_ENABLE_BIT] & global_dma_control[`GDC_MASTER_BIT],
      r.len[`LEN_DIRECTION_BIT],
      sync_match,
      4'h0, r.byte_data};

    if (bus.wr) begin
      unique case (bus.addr)
        `OFS_POINTER_HIGH: n.ptr[17:15] = bus.wdata[2:0];
        `OFS_POINTER_LOW: n.ptr[14:0] = bus.wdata[15:1];
        `OFS_LENGTH_CONTROL: begin
          n.len = bus.wdata;
          n.count = bus.wdata[`LEN_COUNT_MSB:0];
          n.active = bus.wdata[`LEN_ENABLE_BIT];
          n.lo_next = 1'b0;
        end
        `OFS_DATA_WRITE: n.data_buf = bus.wdata;
        `OFS_SYNC_MATCH: n.sync_pattern = bus.wdata;
        default: ;
      endcase
    end

    if (bus.rd) begin
      unique case (bus.addr)
        `OFS_DATA_EARLY_READ: n.rdata = r.data_buf;
        `OFS_BYTE_STATUS: begin
          n.rdata = byte_status;
          n.byte_ready = 1'b0;
        end
        `OFS_INT_ENABLE_READ: n.rdata = int_enable;
        `OFS_INT_REQUEST_READ: n.rdata = int_request;
        default: n.rdata = 16'h0000;
      endcase
    end

    // a new byte wins over the clearing read
    if (disk_rx_valid && !r.len[`LEN_DIRECTION_BIT]) begin
      n.byte_ready = 1'b1;
      n.byte_data = disk_rx_byte;
    end

    // ========================================================================
    // transfer sequencer
    unique case (r.st)
      disk_dma_pkg::DMA_IDLE: begin
        if (r.active && go) begin
          if (r.count == 14'h0000) begin
            n.done = 1'b1;
            n.active = 1'b0;
          end else if (r.len[`LEN_DIRECTION_BIT]) begin
            n.st = disk_dma_pkg::DMA_FETCH;
          end else begin
            n.st = disk_dma_pkg::DMA_COLLECT;
          end
        end
      end
      disk_dma_pkg::DMA_COLLECT: begin
        if (!go) begin
          n.st = disk_dma_pkg::DMA_IDLE;
        end else if (disk_rx_valid) begin
          if (!r.lo_next) begin
            n.data_buf[15:8] = disk_rx_byte;
            n.lo_next = 1'b1;
          end else begin
            n.data_buf[7:0] = disk_rx_byte;
            n.lo_next = 1'b0;
            n.ram = '{req: 1'b1, we: 1'b1, addr: r.ptr,
              wdata: {r.data_buf[15:8], disk_rx_byte}};
            n.st = disk_dma_pkg::DMA_STORE;
          end
        end
      end
      disk_dma_pkg::DMA_STORE: begin
        // the word already sits in the RAM request, so a byte arriving now
        // starts the next word; a second byte before the answer is lost
        if (disk_rx_valid && !r.lo_next) begin
          n.data_buf[15:8] = disk_rx_byte;
          n.lo_next = 1'b1;
        end
        if (ram_ack) begin
          n = advance(n);
          n.ram.req = 1'b0;
          if (r.count == 14'h0001) begin
            n.done = 1'b1;
            n.active = 1'b0;
            n.st = disk_dma_pkg::DMA_IDLE;
          end else begin
            n.st = disk_dma_pkg::DMA_COLLECT;
          end
        end
      end
      disk_dma_pkg::DMA_FETCH: begin
        if (!r.ram.req) begin
          if (go) begin
            n.ram = '{req: 1'b1, we: 1'b0, addr: r.ptr, wdata: 16'h0000};
          end else begin
            n.st = disk_dma_pkg::DMA_IDLE;
          end
        end else if (ram_ack) begin
          n = advance(n);
          n.ram.req = 1'b0;
          n.data_buf = ram_rdata;
          n.tx_valid = 1'b1;
          n.tx_byte = ram_rdata[15:8];
          n.st = disk_dma_pkg::DMA_SEND_HI;
        end
      end
      disk_dma_pkg::DMA_SEND_HI: begin
        if (disk_tx_ready) begin
          n.tx_byte = r.data_buf[7:0];
          n.st = disk_dma_pkg::DMA_SEND_LO;
        end
      end
      disk_dma_pkg::DMA_SEND_LO: begin
        if (disk_tx_ready) begin
          n.tx_valid = 1'b0;
          if (r.count == 14'h0000) begin
            n.done = 1'b1;
            n.active = 1'b0;
            n.st = disk_dma_pkg::DMA_IDLE;
          end else begin
            n.st = disk_dma_pkg::DMA_FETCH;
          end
        end
      end
    endcase

    // ========================================================================
    // interrupt output, registered
    n.irq = int_enable[`INT_MASTER_BIT]
      && |(int_request[13:0] & int_enable[13:0]);
    n.level = int_enable[`INT_MASTER_BIT]
      ? level_of(int_request[13:0] & int_enable[13:0]) : 3'h0;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r <= '{st: disk_dma_pkg::DMA_IDLE, active: 1'b0, ptr: `PTR_RESET,
        len: `REG16_RESET, count: 14'h0000, data_buf: `REG16_RESET,
        lo_next: 1'b0, byte_ready: 1'b0, byte_data: 8'h00,
        sync_pattern: `REG16_RESET, done: 1'b0,
        ram: '{req: 1'b0, we: 1'b0, addr: `PTR_RESET, wdata: `REG16_RESET},
        tx_valid: 1'b0, tx_byte: 8'h00, rdata: `REG16_RESET,
        irq: 1'b0, level: 3'h0};
    end else begin
      r <= n;
    end
  end

  assign rdata = r.rdata;
  assign ram = r.ram;
  assign disk_tx_valid = r.tx_valid;
  assign disk_tx_byte = r.tx_byte;
  assign irq = r.irq;
  assign int_level = r.level;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  length_fields_a: assert property (
    bus.wr && bus.addr == `OFS_LENGTH_CONTROL
    |=> r.count == $past(bus.wdata[13:0]) && r.active == $past(bus.wdata[15]))
    else $error("length write did not load count and enable");

  block_done_a: assert property (
    r.st == disk_dma_pkg::DMA_STORE && ram_ack && r.count == 14'h0001
    |-> ##2 int_request[`INT_BLOCK_BIT])
    else $error("block finished request not raised");

  word_to_disk_a: assert property (
    r.st == disk_dma_pkg::DMA_FETCH && r.ram.req && ram_ack
    |=> disk_tx_valid && disk_tx_byte == $past(ram_rdata[15:8]))
    else $error("fetched word not offered to the disk");

  byte_ready_a: assert property (
    disk_rx_valid && !r.len[`LEN_DIRECTION_BIT]
    |=> r.byte_ready && r.byte_data == $past(disk_rx_byte))
    else $error("read mode byte not captured");

  byte_clear_a: assert property (
    bus.rd && bus.addr == `OFS_BYTE_STATUS && !disk_rx_valid |=> !r.byte_ready)
    else $error("status read did not clear byte ready");

  status_mirror_a: assert property (
    bus.rd && bus.addr == `OFS_BYTE_STATUS
    |=> rdata[14] == $past(r.len[15] & global_dma_control[9])
      && rdata[13] == $past(r.len[14]))
    else $error("status mirrors wrong");

  sync_request_a: assert property (
    sync_found |=> int_request[`INT_SYNC_BIT])
    else $error("sync match did not raise its request");

  irq_gate_a: assert property (
    irq |-> $past(int_enable[14] && |(int_request[13:0] & int_enable[13:0])))
    else $error("interrupt without an enabled request");

  master_only_a: assert property (
    !int_request[`INT_MASTER_BIT] && !int_request[`SET_CLEAR_BIT])
    else $error("master enable appeared as a request");

  dma_gate_a: assert property (
    $rose(r.ram.req) |-> $past(global_dma_control[9] && global_dma_control[4]))
    else $error("disk DMA moved without global enables");

  ram_hold_a: assert property (
    r.ram.req && !ram_ack |=> r.ram.req && r.ram.addr == $past(r.ram.addr))
    else $error("RAM request dropped before its answer");

  block_done_c: cover property (r.done ##2 irq);
  sync_found_c: cover property (sync_found ##1 int_request[`INT_SYNC_BIT]);
  word_sent_c: cover property (
    r.st == disk_dma_pkg::DMA_SEND_LO && disk_tx_ready);
  store_overlap_c: cover property (
    r.st == disk_dma_pkg::DMA_STORE && disk_rx_valid);
endmodule : disk_dma_interrupt_control

//--- verification/disk_link_model.sv
// Purpose: far-side model of the disk block: RAM port and disk byte link
// Assumes: everything runs on clk; signals change by non-blocking assignment at rising edges
// Notes: ram_lat and tx_lat are set by the bench to answer promptly or slowly
`timescale 1ns/1ps
module disk_link_model (
  input wire logic clk, // system clock
  input wire logic reset, // synchronous, active high
  input disk_dma_pkg::ram_req_t ram, // RAM request from the block
  output logic ram_ack, // one-cycle answer
  output logic [15:0] ram_rdata, // word, valid with ram_ack only
  output logic disk_rx_valid, // byte strobe toward the block
  output logic [7:0] disk_rx_byte, // received byte
  input wire logic disk_tx_valid, // byte offered for the disk
  input wire logic [7:0] disk_tx_byte, // byte to write
  output logic disk_tx_ready // disk took the byte
);
  logic [15:0] mem [0:63];
  logic [7:0] tx_q [$];
  int ram_lat = 1;
  int tx_lat = 1;
  int ram_cnt = 0;
  int tx_cnt = 0;
  int ack_count = 0;

  initial begin
    disk_rx_valid = 1'b0;
    disk_rx_byte = 8'h00;
  end

  // ==========================================================================
  // RAM side
  // the data lines toggle outside answers so a stale word is never mistaken for a fresh one
  always @(posedge clk) begin
    ram_ack <= 1'b0;
    ram_rdata <= ~ram_rdata;
    if (reset) begin
      ram_cnt <= 0;
      ram_rdata <= 16'h0000;
    end else if (ram.req && !ram_ack) begin
      if (ram_cnt >= ram_lat) begin
        ram_ack <= 1'b1;
        ram_cnt <= 0;
        ack_count <= ack_count + 1;
        ram_rdata <= mem[ram.addr[5:0]];
        if (ram.we) begin
          mem[ram.addr[5:0]] <= ram.wdata;
        end
      end else begin
        ram_cnt <= ram_cnt + 1;
      end
    end
  end

  // ==========================================================================
  // disk link
  always @(posedge clk) begin
    disk_tx_ready <= 1'b0;
    if (reset) begin
      tx_cnt <= 0;
    end else if (disk_tx_valid && !disk_tx_ready) begin
      if (tx_cnt >= tx_lat) begin
        disk_tx_ready <= 1'b1;
        tx_cnt <= 0;
        tx_q.push_back(disk_tx_byte);
      end else begin
        tx_cnt <= tx_cnt + 1;
      end
    end
  end

  // the byte lines are left inverted when released, never holding the last byte
  task automatic send_byte(input logic [7:0] b);
    @(posedge clk);
    disk_rx_valid <= 1'b1;
    disk_rx_byte <= b;
    @(posedge clk);
    disk_rx_valid <= 1'b0;
    disk_rx_byte <= ~b;
  endtask : send_byte
endmodule : disk_link_model

//--- verification/disk_dma_interrupt_control_tb.sv
// Purpose: self-checking bench for the disk DMA and interrupt block
// Assumes: register bus per the block's one-cycle strobes; far side is disk_link_model
// Notes: every wait is a bounded poll; a poll that runs out ends the run
`timescale 1ns/1ps
`include "disk_dma_consts.svh"
`define CHK(got, exp) begin \
  num_checks++; \
  if ((got) !== (exp)) begin \
    fail_count++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end
module disk_dma_interrupt_control_tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  disk_dma_pkg::reg_bus_t bus = '0;
  logic [15:0] rdata;
  logic [15:0] global_dma_control = 16'h0000;
  logic [15:0] other_events = 16'h0000;
  disk_dma_pkg::ram_req_t ram;
  logic ram_ack;
  logic [15:0] ram_rdata;
  logic disk_rx_valid;
  logic [7:0] disk_rx_byte;
  logic disk_tx_valid;
  logic [7:0] disk_tx_byte;
  logic disk_tx_ready;
  logic irq;
  logic [2:0] int_level;
  logic [15:0] d;
  int fail_count = 0;
  int num_checks = 0;

  always #5 clk = ~clk;

  disk_dma_interrupt_control u_dut (.clk(clk), .reset(reset), .bus(bus), .rdata(rdata),
    .global_dma_control(global_dma_control), .other_events(other_events), .ram(ram),
    .ram_ack(ram_ack), .ram_rdata(ram_rdata), .disk_rx_valid(disk_rx_valid),
    .disk_rx_byte(disk_rx_byte), .disk_tx_valid(disk_tx_valid),
    .disk_tx_byte(disk_tx_byte), .disk_tx_ready(disk_tx_ready), .irq(irq),
    .int_level(int_level));

  disk_link_model u_link (.clk(clk), .reset(reset), .ram(ram), .ram_ack(ram_ack),
    .ram_rdata(ram_rdata), .disk_rx_valid(disk_rx_valid), .disk_rx_byte(disk_rx_byte),
    .disk_tx_valid(disk_tx_valid), .disk_tx_byte(disk_tx_byte),
    .disk_tx_ready(disk_tx_ready));

  // ==========================================================================
  // bus tasks
  task automatic wr(input logic [8:0] a, input logic [15:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask : wr

  // read data stand only in the cycle after the strobe, so they are taken there
  task automatic rd(input logic [8:0] a, output logic [15:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1;
    v = rdata;
  endtask : rd

  task automatic expect_reg(input logic [8:0] a, input logic [15:0] exp);
    logic [15:0] v;
    rd(a, v);
    `CHK(v, exp)
  endtask : expect_reg

  task automatic wait_req(input logic [15:0] m);
    logic [15:0] v;
    int n;
    v = 16'h0000;
    n = 0;
    while ((v & m) !== m && n < 300) begin
      rd(`OFS_INT_REQUEST_READ, v);
      n++;
    end
    num_checks++;
    if ((v & m) !== m) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, v & m, m);
      conclude();
    end
  endtask : wait_req

  task automatic conclude();
    $display("checks=%0d failures=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  // ==========================================================================
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    expect_reg(`OFS_BYTE_STATUS, 16'h0000);
    expect_reg(`OFS_INT_ENABLE_READ, 16'h0000);
    expect_reg(`OFS_INT_REQUEST_READ, 16'h0000);
    expect_reg(9'h100, 16'h0000);
    expect_reg(`OFS_POINTER_HIGH, 16'h0000);
    wr(`OFS_DATA_WRITE, 16'hA5C3);
    expect_reg(`OFS_DATA_EARLY_READ, 16'hA5C3);
    // sync word found, then lost on the next byte
    wr(`OFS_SYNC_MATCH, 16'h4489);
    u_link.send_byte(8'h44);
    u_link.send_byte(8'h89);
    expect_reg(`OFS_BYTE_STATUS, 16'h9089);
    expect_reg(`OFS_BYTE_STATUS, 16'h1089);
    expect_reg(`OFS_INT_REQUEST_READ, 16'h1000);
    `CHK(irq, 1'b0)
    u_link.send_byte(8'h12);
    expect_reg(`OFS_BYTE_STATUS, 16'h8012);
    // enable without the master gate, then with it
    wr(`OFS_INT_ENABLE_WRITE, 16'h9000);
    expect_reg(`OFS_INT_ENABLE_READ, 16'h1000);
    `CHK(irq, 1'b0)
    wr(`OFS_INT_ENABLE_WRITE, 16'hC000);
    expect_reg(`OFS_INT_REQUEST_READ, 16'h1000);
    `CHK(irq, 1'b1)
    `CHK(int_level, 3'h5)
    wr(`OFS_INT_REQUEST_WRITE, 16'h1000);
    expect_reg(`OFS_INT_REQUEST_READ, 16'h0000);
    `CHK(irq, 1'b0)
    @(posedge clk);
    other_events <= 16'h2000;
    @(posedge clk);
    other_events <= 16'h0000;
    wr(`OFS_INT_ENABLE_WRITE, 16'hA000);
    expect_reg(`OFS_INT_REQUEST_READ, 16'h2000);
    `CHK(int_level, 3'h6)
    wr(`OFS_INT_ENABLE_WRITE, 16'h7FFF);
    wr(`OFS_INT_ENABLE_WRITE, 16'hC801);
    expect_reg(`OFS_INT_ENABLE_READ, 16'h4801);
    `CHK(irq, 1'b0)
    wr(`OFS_INT_REQUEST_WRITE, 16'hFFFF);
    expect_reg(`OFS_INT_REQUEST_READ, 16'h3FFF);
    wr(`OFS_INT_REQUEST_WRITE, 16'h7FFF);
    expect_reg(`OFS_INT_REQUEST_READ, 16'h0000);
    // disk to RAM: held off while the master DMA bit is low
    @(posedge clk);
    global_dma_control <= 16'h0010;
    wr(`OFS_POINTER_HIGH, 16'h0000);
    wr(`OFS_POINTER_LOW, 16'h0020);
    wr(`OFS_LENGTH_CONTROL, 16'h8002);
    expect_reg(`OFS_BYTE_STATUS, 16'h0012);
    repeat (20) @(posedge clk);
    `CHK(ram.req, 1'b0)
    global_dma_control <= 16'h0210;
    expect_reg(`OFS_BYTE_STATUS, 16'h4012);
    u_link.send_byte(8'h11);
    u_link.send_byte(8'h22);
    u_link.send_byte(8'h33);
    u_link.send_byte(8'h44);
    wait_req(16'h0002);
    `CHK(u_link.mem[16], 16'h1122)
    `CHK(u_link.mem[17], 16'h3344)
    `CHK(u_link.ack_count, 2)
    wr(`OFS_INT_REQUEST_WRITE, 16'h0002);
    wr(`OFS_INT_ENABLE_WRITE, 16'h8002);
    `CHK(irq, 1'b0)
    // RAM to disk with a slow far side
    u_link.mem[32] = 16'hBEEF;
    u_link.ram_lat = 4;
    u_link.tx_lat = 3;
    wr(`OFS_POINTER_LOW, 16'h0040);
    wr(`OFS_LENGTH_CONTROL, 16'hC001);
    rd(`OFS_BYTE_STATUS, d);
    `CHK(d & 16'h7000, 16'h6000)
    wait_req(16'h0002);
    `CHK(u_link.tx_q.size(), 2)
    `CHK({u_link.tx_q[0], u_link.tx_q[1]}, 16'hBEEF)
    `CHK(u_link.ack_count, 3)
    `CHK(irq, 1'b1)
    `CHK(int_level, 3'h1)
    expect_reg(`OFS_DATA_EARLY_READ, 16'hBEEF);
    conclude();
  end
endmodule : disk_dma_interrupt_control_tb
